// ### verilog/flash_host_map.svh
// Purpose: named constants for the flash command host
// Assumes: 25 MHz clock, byte-wide flash with 17 address lines
// Notes: codes and bus timing counts
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH
`define CMD_READ_ARRAY 8'h00
`define CMD_IDENTIFY 8'h90
`define CMD_ERASE 8'h20
`define CMD_ERASE_CHECK 8'hA0
`define CMD_PROGRAM 8'h40
`define CMD_PROGRAM_CHECK 8'hC0
`define CMD_RESET 8'hFF
`define SIG_MAKER_LOC 17'h00000
`define SIG_PART_LOC 17'h00001
`define STROBE_NS 80
`define CLK_NS 40
`define STROBE_CYC ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W 4
`endif

// ### verilog/flash_host_pkg.sv
// Purpose: types for the flash command host
// Assumes: nothing
// Notes: operation codes of the user port
package flash_host_pkg;
  typedef enum logic [2:0] {
    op_read, op_identify, op_erase, op_erase_check, op_program, op_program_check, op_reset
  } op_t;
  typedef enum logic [2:0] {
    st_idle, st_setup, st_wr_low, st_wr_high, st_rd_low, st_gap
  } state_t;
endpackage

// ### verilog/flash_pin_if.sv
// Purpose: carries flash pin drive between host modules
// Assumes: one clock
// Notes: output enable low means driving
`timescale 1ns/1ns
`default_nettype none
interface flash_pin_if;
  logic select_n;
  logic gate_n;
  logic strobe_n;
  logic [16:0] addr;
  logic [7:0] dq_out;
  logic dq_oe_n;
  modport drv (output select_n, gate_n, strobe_n, addr, dq_out, dq_oe_n);
  modport top (input select_n, gate_n, strobe_n, addr, dq_out, dq_oe_n);
endinterface
`default_nettype wire

// ### verilog/flash_pin_driver.sv
// Purpose: registers the flash pins for one bus phase
// Assumes: phase chosen by the sequencer
// Notes: all pin drive comes from flip-flops
`timescale 1ns/1ns
`default_nettype none
module flash_pin_driver
  import flash_host_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_sel,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_drive,
  input wire logic [16:0] i_addr,
  input wire logic [7:0] i_data,
  flash_pin_if.drv pins
);
  logic select_n, gate_n, strobe_n, dq_oe_n;
  logic next_select_n, next_gate_n, next_strobe_n, next_dq_oe_n;
  logic [16:0] addr, next_addr;
  logic [7:0] dq_out, next_dq_out;
  always_comb begin
    next_select_n = ~i_sel;
    next_strobe_n = ~i_wr;
    next_gate_n = ~i_rd;
    next_dq_oe_n = ~i_drive;
    next_addr = i_addr;
    next_dq_out = i_data;
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      select_n <= 1'b1;
      gate_n <= 1'b1;
      strobe_n <= 1'b1;
      dq_oe_n <= 1'b1;
      addr <= 17'h00000;
      dq_out <= 8'h00;
    end else begin
      select_n <= next_select_n;
      gate_n <= next_gate_n;
      strobe_n <= next_strobe_n;
      dq_oe_n <= next_dq_oe_n;
      addr <= next_addr;
      dq_out <= next_dq_out;
    end
  end
  assign pins.select_n = select_n;
  assign pins.gate_n = gate_n;
  assign pins.strobe_n = strobe_n;
  assign pins.addr = addr;
  assign pins.dq_out = dq_out;
  assign pins.dq_oe_n = dq_oe_n;
endmodule
`default_nettype wire

// ### verilog/flash_command_host.sv
// Purpose: host sequencer driving a byte-wide flash through its pins
// Assumes: flash pins sampled synchronously to i_clk
// Notes: one user operation at a time, o_ready shows idle
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_map.svh"
module flash_command_host
  import flash_host_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire op_t i_op,
  input wire logic [16:0] i_addr,
  input wire logic [7:0] i_data,
  input wire logic i_program_supply_high,
  input wire logic i_supply_ok,
  output logic o_ready,
  output logic o_done,
  output logic o_refused,
  output logic [7:0] o_rdata,
  output logic o_select_n,
  output logic o_gate_n,
  output logic o_strobe_n,
  output logic [16:0] o_addr,
  output logic [7:0] o_dq,
  output logic o_dq_oe_n,
  input wire logic [7:0] i_dq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  state_t state, next_state;
  logic [`CNT_W-1:0] cnt, next_cnt;
  logic second, next_second;
  logic want_read, next_want_read;
  logic [7:0] wcode, next_wcode;
  logic [16:0] waddr, next_waddr;
  logic [7:0] second_code, next_second_code;
  logic [16:0] second_addr, next_second_addr;
  logic [7:0] rdata, next_rdata;
  logic done, next_done, refused, next_refused;
  logic sel, wr, rd, drive;
  logic altering;
  flash_pin_if pins();
  flash_pin_driver u_drv (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_sel(sel),
    .i_wr(wr),
    .i_rd(rd),
    .i_drive(drive),
    .i_addr(waddr),
    .i_data(wcode),
    .pins(pins)
  );
  assign altering = (i_op != op_read);
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_second = second;
    next_want_read = want_read;
    next_wcode = wcode;
    next_waddr = waddr;
    next_second_code = second_code;
    next_second_addr = second_addr;
    next_rdata = rdata;
    next_done = 1'b0;
    next_refused = 1'b0;
    sel = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    drive = 1'b0;
    unique case (state)
      st_idle: begin
        if (i_start) begin
          if (altering && (!i_program_supply_high || !i_supply_ok)) begin
            next_refused = 1'b1;
          end else if (i_op == op_read && !(i_program_supply_high && i_supply_ok)) begin
            next_waddr = i_addr;
            next_want_read = 1'b0;
            next_cnt = '0;
            next_state = st_rd_low;
          end else begin
            next_state = st_setup;
          end
        end
      end
      st_setup: begin
        next_second = 1'b0;
        next_want_read = 1'b0;
        next_second_code = i_data;
        next_second_addr = i_addr;
        next_waddr = 17'h00000;
        next_cnt = '0;
        next_state = st_wr_low;
        unique case (i_op)
          op_read: begin
            next_wcode = `CMD_READ_ARRAY;
            next_second_addr = i_addr;
            next_want_read = 1'b1;
          end
          op_identify: begin
            next_wcode = `CMD_IDENTIFY;
            next_waddr = i_addr[0] ? `SIG_PART_LOC : `SIG_MAKER_LOC;
            next_second_addr = next_waddr;
            next_want_read = 1'b1;
          end
          op_erase: begin
            next_wcode = `CMD_ERASE;
            next_second_code = `CMD_ERASE;
            next_second = 1'b1;
          end
          op_erase_check: begin
            next_wcode = `CMD_ERASE_CHECK;
            next_waddr = i_addr;
            next_second_addr = i_addr;
            next_want_read = 1'b1;
          end
          op_program: begin
            next_wcode = `CMD_PROGRAM;
            next_second = 1'b1;
          end
          // no new address, also ends timer idle
          op_program_check: begin
            next_wcode = `CMD_PROGRAM_CHECK;
            next_second_addr = 17'h00000;
            next_want_read = 1'b1;
          end
          op_reset: begin
            next_wcode = `CMD_RESET;
            next_second_code = `CMD_RESET;
            next_second = 1'b1;
          end
          default: begin
            next_refused = 1'b1;
            next_state = st_idle;
          end
        endcase
      end
      // strobe low only with select low
      st_wr_low: begin
        sel = 1'b1;
        // address settles a cycle before strobe falls
        wr = (cnt != '0);
        drive = 1'b1;
        next_cnt = cnt + 1'b1;
        if (cnt == `CNT_W'(`STROBE_CYC)) begin
          next_cnt = '0;
          next_state = st_wr_high;
        end
      end
      st_wr_high: begin
        sel = 1'b1;
        drive = 1'b1;
        if (second) begin
          next_second = 1'b0;
          next_wcode = second_code;
          next_waddr = second_addr;
          next_state = st_wr_low;
        end else if (want_read) begin
          next_waddr = second_addr;
          next_state = st_rd_low;
        end else begin
          next_state = st_gap;
        end
      end
      // read with select and gate low
      st_rd_low: begin
        sel = 1'b1;
        rd = 1'b1;
        next_cnt = cnt + 1'b1;
        if (cnt == `CNT_W'(`STROBE_CYC)) begin
          next_rdata = i_dq;
          next_cnt = '0;
          next_state = st_gap;
        end
      end
      st_gap: begin
        next_done = 1'b1;
        next_state = st_idle;
      end
      default: next_state = st_idle;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state <= st_idle;
      cnt <= '0;
      second <= 1'b0;
      want_read <= 1'b0;
      wcode <= `CMD_READ_ARRAY;
      waddr <= 17'h00000;
      second_code <= 8'h00;
      second_addr <= 17'h00000;
      rdata <= 8'h00;
      done <= 1'b0;
      refused <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      second <= next_second;
      want_read <= next_want_read;
      wcode <= next_wcode;
      waddr <= next_waddr;
      second_code <= next_second_code;
      second_addr <= next_second_addr;
      rdata <= next_rdata;
      done <= next_done;
      refused <= next_refused;
    end
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_ready = (state == st_idle);
  assign o_done = done;
  assign o_refused = refused;
  assign o_rdata = rdata;
  assign o_select_n = pins.select_n;
  assign o_gate_n = pins.gate_n;
  assign o_strobe_n = pins.strobe_n;
  assign o_addr = pins.addr;
  assign o_dq = pins.dq_out;
  assign o_dq_oe_n = pins.dq_oe_n;
endmodule
`default_nettype wire

// ### dv/flash_dev_model.sv
// Purpose: behavioural byte-wide flash
// Assumes: supply levels given as flags
// Notes: released pins invert their last value on every change
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model #(
  parameter logic [7:0] MAKER = 8'h5A, // arbitrary
  parameter logic [7:0] PART = 8'hC3 // arbitrary
) (
  input wire logic i_select_n,
  input wire logic i_gate_n,
  input wire logic i_strobe_n,
  input wire logic [16:0] i_addr,
  input wire logic [7:0] i_dq,
  input wire logic i_program_supply_high,
  input wire logic i_supply_ok,
  input wire logic i_sig_hv,
  output logic [7:0] o_dq
);
  logic [7:0] mem [int];
  logic [7:0] cmd = 8'h00;
  logic [16:0] lat = 17'h00000;
  logic [16:0] prog = 17'h00000;
  logic [7:0] rd;
  initial o_dq = 8'h00;
  function automatic logic [7:0] arr(input logic [16:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  always @(negedge i_program_supply_high) cmd = 8'h00;
  always @(negedge i_strobe_n) if (!i_select_n) lat = i_addr;
  // work ends at once, deselect never stops it
  always @(posedge i_strobe_n) begin
    if (!i_select_n && i_supply_ok && i_program_supply_high) begin
      if (cmd == 8'h40) begin
        mem[lat] = i_dq;
        prog = lat;
        cmd = 8'h01;
      end else if (cmd == 8'h20 && i_dq == 8'h20) begin
        mem.delete();
        cmd = 8'h01;
      end else cmd = i_dq;
    end
  end
  always @(i_addr, cmd, lat, prog, i_program_supply_high, i_sig_hv) begin
    case (i_program_supply_high ? cmd : 8'h00)
      8'h90: rd = i_addr[0] ? PART : MAKER;
      8'hA0: rd = arr(lat);
      8'hC0: rd = arr(prog);
      default: rd = arr(i_addr);
    endcase
    // raised address line nine gives signature
    if (i_sig_hv) rd = i_addr[0] ? PART : MAKER;
  end
  always @(i_select_n, i_gate_n, rd) o_dq = (!i_select_n && !i_gate_n) ? rd : ~o_dq;
endmodule
`default_nettype wire

// ### dv/flash_host_properties.sv
// Purpose: pin checks for the flash host
// Assumes: bound to the host top
// Notes: one clock domain
`timescale 1ns/1ns
`default_nettype none
module flash_host_properties
  import flash_host_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire op_t i_op,
  input wire logic [16:0] i_addr,
  input wire logic [7:0] i_data,
  input wire logic i_program_supply_high,
  input wire logic i_supply_ok,
  input wire logic o_ready,
  input wire logic o_done,
  input wire logic o_refused,
  input wire logic [7:0] o_rdata,
  input wire logic o_select_n,
  input wire logic o_gate_n,
  input wire logic o_strobe_n,
  input wire logic [16:0] o_addr,
  input wire logic [7:0] o_dq,
  input wire logic o_dq_oe_n,
  input wire logic [7:0] i_dq
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  sequence strobe_low2;
    !o_strobe_n ##1 !o_strobe_n ##1 o_strobe_n;
  endsequence
  sequence take_alter;
    o_ready && i_start && i_op != op_read && !(i_program_supply_high && i_supply_ok);
  endsequence
  write_sel_a: assert property (!o_strobe_n |-> !o_select_n && o_gate_n && !o_dq_oe_n)
    else $error("strobe without select");
  read_gate_a: assert property (!o_gate_n |-> !o_select_n && o_dq_oe_n && o_strobe_n)
    else $error("bad read gate");
  standby_quiet_a: assert property (o_select_n |-> o_strobe_n && o_gate_n)
    else $error("strobe in standby");
  strobe_width_a: assert property ($fell(o_strobe_n) |-> strobe_low2)
    else $error("bad strobe width");
  write_hold_a: assert property (!o_strobe_n && !$fell(o_strobe_n) |-> $stable(o_addr)
    && $stable(o_dq)) else $error("write not held");
  refuse_pulse_a: assert property (take_alter |=> o_refused ##1 !o_refused)
    else $error("no refusal");
  refuse_quiet_a: assert property (take_alter |=> o_select_n [*3])
    else $error("pins moved on refusal");
  done_pulse_a: assert property (o_done |=> !o_done && o_ready)
    else $error("bad done");
  op_ends_a: assert property (o_ready && i_start |=> ##[0:60] (o_done || o_refused))
    else $error("op never ends");
endmodule
bind flash_command_host flash_host_properties chk (.*);
`default_nettype wire

// ### dv/testbench.sv
// Purpose: self-checking bench for the flash host
// Assumes: device model on the far side
// Notes: random program and check, fixed seed
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import flash_host_pkg::*;
  localparam logic [7:0] MAKER = 8'h5A; // arbitrary
  localparam logic [7:0] PART = 8'hC3; // arbitrary
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_start = 1'b0;
  op_t i_op = op_read;
  logic [16:0] i_addr = 17'h00000;
  logic [7:0] i_data = 8'h00;
  logic i_program_supply_high = 1'b1;
  logic i_supply_ok = 1'b1;
  logic sig_hv = 1'b0;
  logic o_ready, o_done, o_refused, o_select_n, o_gate_n, o_strobe_n, o_dq_oe_n;
  logic [7:0] o_rdata, o_dq, dev_dq;
  logic [16:0] o_addr;
  wire logic [7:0] i_dq = o_dq_oe_n ? dev_dq : o_dq;
  int fails = 0;
  int n_checks = 0;
  int seed = 32'h55923503;
  logic [7:0] ref_mem [int];
  logic refused;
  initial forever #20 i_clk = ~i_clk;
  flash_command_host dut (.*);
  flash_dev_model #(.MAKER(MAKER), .PART(PART)) dev (.i_select_n(o_select_n),
    .i_gate_n(o_gate_n), .i_strobe_n(o_strobe_n), .i_addr(o_addr), .i_dq(i_dq),
    .i_sig_hv(sig_hv),
    .i_program_supply_high(i_program_supply_high), .i_supply_ok(i_supply_ok), .o_dq(dev_dq));
  function automatic logic [7:0] exp_rd(input logic [16:0] a);
    return ref_mem.exists(a) ? ref_mem[a] : 8'hFF;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic run(input op_t o, input logic [16:0] a, input logic [7:0] d);
    int k;
    @(posedge i_clk);
    i_start <= 1'b1;
    i_op <= o;
    i_addr <= a;
    i_data <= d;
    @(posedge i_clk);
    i_start <= 1'b0;
    for (k = 0; k < 100; k++) begin
      #1;
      if ((o_done | o_refused) === 1'b1) break;
      @(posedge i_clk);
    end
    refused = o_refused;
    if (k == 100) begin
      fails++;
      stop_test();
    end
  endtask
  initial begin
    logic [31:0] r;
    logic [16:0] a;
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    for (int i = 0; i < 14; i++) begin
      r = $random(seed);
      a = (i == 0) ? 17'h1FFFF : r[16:0];
      ref_mem[a] = (i == 1) ? 8'h00 : r[24:17];
      run(op_program, a, ref_mem[a]);
      run(op_program_check, 17'h00000, 8'h00);
      check(o_rdata, exp_rd(a));
      run(op_read, a, 8'h00);
      check(o_rdata, exp_rd(a));
    end
    run(op_identify, 17'h00000, 8'h00);
    check(o_rdata, MAKER);
    run(op_identify, 17'h00001, 8'h00);
    check(o_rdata, PART);
    run(op_erase, 17'h00000, 8'h00);
    ref_mem.delete();
    run(op_erase_check, a, 8'h00);
    check(o_rdata, 8'hFF);
    run(op_program, a, 8'h3C);
    ref_mem[a] = 8'h3C;
    run(op_erase_check, a, 8'h00);
    check(o_rdata, 8'h3C);
    run(op_reset, 17'h00000, 8'h00);
    check({7'h00, refused}, 8'h00);
    for (int s = 0; s < 2; s++) begin
      @(posedge i_clk);
      i_program_supply_high <= (s == 1);
      i_supply_ok <= (s == 0);
      for (int j = 1; j < 7; j++) begin
        run(op_t'(j), a, 8'h5A);
        check({7'h00, refused}, 8'h01);
      end
      run(op_read, a, 8'h00);
      check(o_rdata, exp_rd(a));
    end
    @(posedge i_clk);
    sig_hv <= 1'b1;
    run(op_read, 17'h00001, 8'h00);
    check(o_rdata, PART);
    stop_test();
  end
endmodule
`default_nettype wire
